// file: src/srg_gater.sv
`timescale 1ns/10ps
`include "srg_cfg.svh"

module srg_gater #(
    parameter int NUM_VARS = 16
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          cmdValid,
    output logic                               cmdReady,
    input  wire srg_pkg::srg_cmd_type          cmd,
    input  wire logic                          varWrite,
    input  wire logic [`SRG_VAR_SEL_W-1:0]     varIndex,
    input  wire logic [`SRG_PHASE_W-1:0]       varData,
    output srg_pkg::srg_rf_type                rf,
    output logic                               busy
);

    localparam int CH = `SRG_CHANNELS;
    // least times round up to whole cycles
    localparam int MIN_DIFF_CYC = (`SRG_MIN_DIFF_NS * 1000 + `SRG_CLK_PERIOD_PS - 1) / `SRG_CLK_PERIOD_PS;
    localparam int EXT_DIFF_CYC = (`SRG_EXT_DIFF_NS * 1000 + `SRG_CLK_PERIOD_PS - 1) / `SRG_CLK_PERIOD_PS;
    localparam int OVH_TWO_CYC  = (`SRG_OVH_TWO_NS * 1000 + `SRG_CLK_PERIOD_PS - 1) / `SRG_CLK_PERIOD_PS;
    localparam int OVH_THREE_CYC = (`SRG_OVH_THREE_NS * 1000 + `SRG_CLK_PERIOD_PS - 1) / `SRG_CLK_PERIOD_PS;
    localparam srg_pkg::srg_count_type MIN_DIFF  = srg_pkg::srg_count_type'(MIN_DIFF_CYC);
    localparam srg_pkg::srg_count_type EXT_DIFF  = srg_pkg::srg_count_type'(EXT_DIFF_CYC);
    localparam srg_pkg::srg_count_type OVH_TWO   = srg_pkg::srg_count_type'(OVH_TWO_CYC);
    localparam srg_pkg::srg_count_type OVH_THREE = srg_pkg::srg_count_type'(OVH_THREE_CYC);
    localparam srg_pkg::srg_count_type ONE       = srg_pkg::srg_count_type'(1);

    srg_pkg::srg_state_type                    state;
    srg_pkg::srg_state_type                    next_state;
    srg_pkg::srg_cmd_type                      cmdReg;
    srg_pkg::srg_cmd_type                      next_cmdReg;
    srg_pkg::srg_count_type                    cnt;
    srg_pkg::srg_count_type                    next_cnt;
    srg_pkg::srg_count_type                    maxW;
    srg_pkg::srg_count_type                    next_maxW;
    srg_pkg::srg_count_type [CH-1:0]           effW;
    srg_pkg::srg_count_type [CH-1:0]           next_effW;
    srg_pkg::srg_count_type [CH-1:0]           startC;
    srg_pkg::srg_count_type [CH-1:0]           next_startC;
    srg_pkg::srg_count_type [CH-1:0]           stopC;
    srg_pkg::srg_count_type [CH-1:0]           next_stopC;
    srg_pkg::srg_count_type                    ovhLen;
    srg_pkg::srg_count_type                    next_ovhLen;
    srg_pkg::srg_rf_type                       next_rf;
    logic [`SRG_PHASE_W-1:0]                   phaseVars [NUM_VARS];
    logic [`SRG_PHASE_W-1:0]                   next_phaseVars [NUM_VARS];
    logic                                      shaped;
    logic [CH-1:0]                             chanMask;
    srg_pkg::srg_count_type                    cmdMax;
    srg_pkg::srg_count_type                    diff;

    assign shaped   = (cmdReg.mode == srg_pkg::MODE_SHAPED2) || (cmdReg.mode == srg_pkg::MODE_SHAPED3);
    assign cmdReady = (state == srg_pkg::ST_IDLE);
    assign busy     = (state != srg_pkg::ST_IDLE);

    // channels that the chosen operation may use
    always_comb
    begin
        unique case (cmd.mode)
            srg_pkg::MODE_THREE:   chanMask = `SRG_MASK_THREE;
            srg_pkg::MODE_FOUR:    chanMask = `SRG_MASK_FOUR;
            srg_pkg::MODE_SHAPED2: chanMask = `SRG_MASK_SHAPED2;
            srg_pkg::MODE_SHAPED3: chanMask = `SRG_MASK_SHAPED3;
        endcase
    end

    // run-time phase variables, written by the sequencer core
    always_comb
    begin
        next_phaseVars = phaseVars;
        if (varWrite)
        begin
            next_phaseVars[varIndex] = varData;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int v = 0; v < NUM_VARS; v++)
            begin
                phaseVars[v] <= '0;
            end
        end
        else
        begin
            phaseVars <= next_phaseVars;
        end
    end

    // phase of every channel, zero width ones too, is set as lead begins
    function automatic srg_pkg::srg_rf_type loadPhases(input srg_pkg::srg_rf_type cur);
        srg_pkg::srg_rf_type r;
        r = cur;
        for (int i = 0; i < CH; i++)
        begin
            r.phase[i] = phaseVars[cmdReg.phaseSel[i]];
        end
        r.phaseLoad = 1'b1;
        return r;
    endfunction

    // sequencer: next values
    always_comb
    begin
        next_state  = state;
        next_cmdReg = cmdReg;
        next_cnt    = cnt + ONE;
        next_maxW   = maxW;
        next_effW   = effW;
        next_startC = startC;
        next_stopC  = stopC;
        next_ovhLen = ovhLen;
        next_rf     = rf;
        next_rf.phaseLoad = 1'b0;
        cmdMax      = '0;
        diff        = '0;
        unique case (state)
            srg_pkg::ST_IDLE:
            begin
                next_cnt = '0;
                if (cmdValid)
                begin
                    next_cmdReg = cmd;
                    for (int i = 0; i < CH; i++)
                    begin
                        // channels outside the operation carry zero width
                        if (!chanMask[i])
                        begin
                            next_cmdReg.width[i] = '0;
                            next_cmdReg.shape[i] = `SRG_NO_SHAPE;
                        end
                    end
                    next_state = srg_pkg::ST_PREP;
                end
            end
            srg_pkg::ST_PREP:
            begin
                next_cnt = '0;
                for (int i = 0; i < CH; i++)
                begin
                    if (cmdReg.width[i] > cmdMax)
                    begin
                        cmdMax = cmdReg.width[i];
                    end
                end
                next_maxW = cmdMax;
                for (int i = 0; i < CH; i++)
                begin
                    diff = cmdMax - cmdReg.width[i];
                    if (cmdReg.width[i] == '0)
                    begin
                        next_effW[i] = '0;
                    end
                    else if (diff < MIN_DIFF)
                    begin
                        next_effW[i] = cmdMax;
                    end
                    else if (diff < EXT_DIFF && cmdMax > EXT_DIFF)
                    begin
                        next_effW[i] = cmdMax - EXT_DIFF;
                    end
                    else
                    begin
                        next_effW[i] = cmdReg.width[i];
                    end
                    // centre on the longest pulse; odd slack puts the extra tick after
                    next_startC[i] = (cmdMax - next_effW[i]) >> 1;
                    next_stopC[i]  = next_startC[i] + next_effW[i];
                    // only a real shaped channel engages its waveform generator
                    next_rf.waveShape[i] = (shaped && cmdReg.width[i] != '0)
                                           ? cmdReg.shape[i] : `SRG_NO_SHAPE;
                end
                // overhead depends on the operation only, never on widths
                next_ovhLen = (cmdReg.mode == srg_pkg::MODE_SHAPED2) ? OVH_TWO : OVH_THREE;
                if (shaped)
                begin
                    next_state = srg_pkg::ST_OVERHEAD;
                end
                else
                begin
                    next_state = (cmdReg.lead == '0) ? srg_pkg::ST_PULSE : srg_pkg::ST_LEAD;
                    next_rf    = loadPhases(next_rf);
                end
            end
            srg_pkg::ST_OVERHEAD:
            begin
                if (cnt == ovhLen - ONE)
                begin
                    next_cnt   = '0;
                    next_state = (cmdReg.lead == '0) ? srg_pkg::ST_PULSE : srg_pkg::ST_LEAD;
                    next_rf    = loadPhases(next_rf);
                end
            end
            srg_pkg::ST_LEAD:
            begin
                if (cnt == cmdReg.lead - ONE)
                begin
                    next_cnt   = '0;
                    next_state = srg_pkg::ST_PULSE;
                end
            end
            srg_pkg::ST_PULSE:
            begin
                // an all-zero group still opens and closes the amplifier window
                if (maxW == '0 || cnt == maxW - ONE)
                begin
                    next_cnt   = '0;
                    next_state = (cmdReg.lag == '0) ? srg_pkg::ST_IDLE : srg_pkg::ST_LAG;
                end
            end
            srg_pkg::ST_LAG:
            begin
                if (cnt == cmdReg.lag - ONE)
                begin
                    next_cnt   = '0;
                    next_state = srg_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_cnt   = '0;
                next_state = srg_pkg::ST_IDLE;
            end
        endcase
        next_rf.ampGate = (next_state == srg_pkg::ST_LEAD) || (next_state == srg_pkg::ST_PULSE)
                          || (next_state == srg_pkg::ST_LAG);
        for (int i = 0; i < CH; i++)
        begin
            next_rf.gate[i] = (next_state == srg_pkg::ST_PULSE) && (next_cnt >= next_startC[i])
                              && (next_cnt < next_stopC[i]);
            // no shape: plain rectangular gate with the generator left idle
            next_rf.waveEngage[i] = next_rf.gate[i] && (next_rf.waveShape[i] != `SRG_NO_SHAPE);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state  <= srg_pkg::ST_IDLE;
            cmdReg <= '0;
            cnt    <= '0;
            maxW   <= '0;
            effW   <= '0;
            startC <= '0;
            stopC  <= '0;
            ovhLen <= '0;
            rf     <= '0;
        end
        else
        begin
            state  <= next_state;
            cmdReg <= next_cmdReg;
            cnt    <= next_cnt;
            maxW   <= next_maxW;
            effW   <= next_effW;
            startC <= next_startC;
            stopC  <= next_stopC;
            ovhLen <= next_ovhLen;
            rf     <= next_rf;
        end
    end

    a_tx_inside_amp: assert property (@(posedge clk_sys) disable iff (rst)
        (|rf.gate) |-> rf.ampGate)
        else $error("transmitter on outside amplifier window");

    a_lead_before_tx: assert property (@(posedge clk_sys) disable iff (rst)
        (state == srg_pkg::ST_LEAD && cnt == cmdReg.lead - ONE) |=> (state == srg_pkg::ST_PULSE) && !$past(|rf.gate))
        else $error("lead interval length wrong");

    a_lag_after_tx: assert property (@(posedge clk_sys) disable iff (rst)
        ($past(state) == srg_pkg::ST_PULSE && state == srg_pkg::ST_LAG) |-> rf.ampGate && !(|rf.gate))
        else $error("amplifier dropped at start of lag");

    a_lag_length: assert property (@(posedge clk_sys) disable iff (rst)
        (state == srg_pkg::ST_LAG && cnt == cmdReg.lag - ONE) |=> !rf.ampGate && state == srg_pkg::ST_IDLE)
        else $error("lag interval length wrong");

    a_zero_width_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (state == srg_pkg::ST_PULSE && effW[0] == '0) |-> !rf.gate[0])
        else $error("zero width channel pulsed");

    a_phase_at_lead: assert property (@(posedge clk_sys) disable iff (rst)
        rf.phaseLoad |-> rf.ampGate && $past(state) inside {srg_pkg::ST_PREP, srg_pkg::ST_OVERHEAD})
        else $error("phase load not at lead start");

    a_overhead_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        ($past(state) == srg_pkg::ST_OVERHEAD && state != srg_pkg::ST_OVERHEAD)
        |-> $past(cnt) == (cmdReg.mode == srg_pkg::MODE_SHAPED2 ? OVH_TWO : OVH_THREE) - ONE)
        else $error("shaped overhead length wrong");

    a_wave_needs_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (|rf.waveEngage) |-> (rf.waveEngage & ~rf.gate) == '0 && shaped)
        else $error("waveform engaged without pulse");

    a_equal_small_diff: assert property (@(posedge clk_sys) disable iff (rst)
        (state == srg_pkg::ST_PULSE && effW[1] != '0) |-> (maxW == effW[1] || maxW - effW[1] >= MIN_DIFF))
        else $error("sub-minimum width difference");

    a_centred_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (state == srg_pkg::ST_PULSE) |-> startC[0] + startC[0] + effW[0] <= maxW
        && maxW - (startC[0] + startC[0] + effW[0]) <= ONE)
        else $error("pulse not centred");

endmodule

// file: src/srg_cfg.svh
`ifndef SRG_CFG_SVH
`define SRG_CFG_SVH

`define SRG_CHANNELS        4
`define SRG_WIDTH_W         24
`define SRG_PHASE_W         8
`define SRG_VAR_SEL_W       4
`define SRG_SHAPE_W         6
`define SRG_NO_SHAPE        6'h00

`define SRG_CLK_PERIOD_PS   8000
`define SRG_MIN_DIFF_NS     100
`define SRG_EXT_DIFF_NS     200
`define SRG_OVH_TWO_NS      1450
`define SRG_OVH_THREE_NS    1950

`define SRG_MASK_THREE      4'h7
`define SRG_MASK_FOUR       4'hf
`define SRG_MASK_SHAPED2    4'h3
`define SRG_MASK_SHAPED3    4'h7

`endif

// file: src/srg_pkg.sv
`include "srg_cfg.svh"

package srg_pkg;

    typedef enum logic [1:0] {
        MODE_THREE   = 2'b00,
        MODE_FOUR    = 2'b01,
        MODE_SHAPED2 = 2'b10,
        MODE_SHAPED3 = 2'b11
    } srg_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_PREP     = 3'b001,
        ST_OVERHEAD = 3'b010,
        ST_LEAD     = 3'b011,
        ST_PULSE    = 3'b100,
        ST_LAG      = 3'b101
    } srg_state_type;

    typedef logic [`SRG_WIDTH_W-1:0] srg_count_type;

    // channel 0 observe, 1 first decoupler, 2 second decoupler, 3 third decoupler
    typedef struct packed {
        srg_mode_type                                           mode;
        logic [`SRG_CHANNELS-1:0][`SRG_WIDTH_W-1:0]             width;
        logic [`SRG_CHANNELS-1:0][`SRG_VAR_SEL_W-1:0]           phaseSel;
        logic [`SRG_CHANNELS-1:0][`SRG_SHAPE_W-1:0]             shape;
        srg_count_type                                          lead;
        srg_count_type                                          lag;
    } srg_cmd_type;

    typedef struct packed {
        logic [`SRG_CHANNELS-1:0]                               gate;
        logic [`SRG_CHANNELS-1:0]                               waveEngage;
        logic [`SRG_CHANNELS-1:0][`SRG_SHAPE_W-1:0]             waveShape;
        logic [`SRG_CHANNELS-1:0][`SRG_PHASE_W-1:0]             phase;
        logic                                                   phaseLoad;
        logic                                                   ampGate;
    } srg_rf_type;

endpackage

// file: sim/srg_rf_model.sv
`timescale 1ns/10ps

module srg_rf_model (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire srg_pkg::srg_rf_type rf,
    output logic [31:0]              cyc,
    output logic [31:0]              ampRiseCyc,
    output logic [31:0]              ampLen,
    output logic [3:0][31:0]         gateOn,
    output logic [3:0][31:0]         gateLen,
    output logic [31:0]              loadCount,
    output logic [31:0]              loadAt,
    output logic [31:0]              stray
);
    logic        ampPrev;
    logic [3:0]  gatePrev;
    logic [31:0] cnt;
    logic [31:0] now;
    logic        rise;
    logic        bad;

    // transmitters only listen; they measure each group from the amp gate rise
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cyc        <= '0;
            ampPrev    <= 1'b0;
            gatePrev   <= '0;
            cnt        <= '0;
            ampRiseCyc <= '0;
            ampLen     <= '0;
            gateOn     <= '0;
            gateLen    <= '0;
            loadCount  <= '0;
            loadAt     <= '0;
            stray      <= '0;
        end
        else
        begin
            rise = rf.ampGate && !ampPrev;
            now  = rise ? 32'h0 : cnt;
            bad  = (|rf.gate) && !rf.ampGate;
            cyc      <= cyc + 1;
            ampPrev  <= rf.ampGate;
            gatePrev <= rf.gate;
            cnt      <= now + 1;
            ampLen   <= (rise ? 32'h0 : ampLen) + 32'(rf.ampGate);
            loadCount <= (rise ? 32'h0 : loadCount) + 32'(rf.phaseLoad);
            if (rise)
            begin
                ampRiseCyc <= cyc;
                gateOn     <= '0;
            end
            if (rf.phaseLoad)
                loadAt <= now;
            for (int i = 0; i < 4; i++)
            begin
                // the generator runs exactly while a shaped gate is open
                if (rf.waveEngage[i] != (rf.gate[i] && rf.waveShape[i] != '0))
                    bad = 1'b1;
                gateLen[i] <= (rise ? 32'h0 : gateLen[i]) + 32'(rf.gate[i]);
                if (rf.gate[i] && !gatePrev[i])
                    gateOn[i] <= now;
            end
            stray <= stray + 32'(bad);
        end
    end
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
`include "srg_cfg.svh"

module testbench;
    logic                          clk_sys;
    logic                          rst;
    logic                          cmdValid;
    logic                          cmdReady;
    srg_pkg::srg_cmd_type          cmd;
    logic                          varWrite;
    logic [`SRG_VAR_SEL_W-1:0]     varIndex;
    logic [`SRG_PHASE_W-1:0]       varData;
    srg_pkg::srg_rf_type           rf;
    logic                          busy;
    logic [31:0]                   cyc, ampRiseCyc, ampLen, loadCount, loadAt, stray;
    logic [3:0][31:0]              gateOn;
    logic [3:0][31:0]              gateLen;
    logic [`SRG_PHASE_W-1:0]       vars [16];
    int                            num_errors;
    int                            check_count;

    function automatic int ticks(input int ns);
        return (ns * 1000 + `SRG_CLK_PERIOD_PS - 1) / `SRG_CLK_PERIOD_PS;
    endfunction

    srg_gater #(.NUM_VARS(16)) u_srg_gater (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmd(cmd), .varWrite(varWrite), .varIndex(varIndex), .varData(varData),
        .rf(rf), .busy(busy));
    srg_rf_model u_srg_rf_model (.clk_sys(clk_sys), .rst(rst), .rf(rf), .cyc(cyc), .ampRiseCyc(ampRiseCyc),
        .ampLen(ampLen), .gateOn(gateOn), .gateLen(gateLen), .loadCount(loadCount), .loadAt(loadAt),
        .stray(stray));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // effective widths after mode masking and difference equalisation
    function automatic logic [3:0][31:0] eff_widths(input srg_pkg::srg_cmd_type c, output logic [31:0] mx,
                                                     output logic [3:0] mask);
        logic [3:0][31:0] w;
        case (c.mode)
            srg_pkg::MODE_THREE:   mask = `SRG_MASK_THREE;
            srg_pkg::MODE_FOUR:    mask = `SRG_MASK_FOUR;
            srg_pkg::MODE_SHAPED2: mask = `SRG_MASK_SHAPED2;
            default:               mask = `SRG_MASK_SHAPED3;
        endcase
        mx = 0;
        for (int i = 0; i < 4; i++)
        begin
            w[i] = mask[i] ? 32'(c.width[i]) : 32'h0;
            if (w[i] > mx)
                mx = w[i];
        end
        for (int i = 0; i < 4; i++)
        begin
            if (w[i] != 0 && mx - w[i] < ticks(`SRG_MIN_DIFF_NS))
                w[i] = mx;
            else if (w[i] != 0 && mx - w[i] < ticks(`SRG_EXT_DIFF_NS) && mx > ticks(`SRG_EXT_DIFF_NS))
                w[i] = mx - ticks(`SRG_EXT_DIFF_NS);
        end
        return w;
    endfunction

    task automatic write_var(input logic [3:0] idx, input logic [7:0] data);
        @(negedge clk_sys);
        varWrite = 1'b1;
        varIndex = idx;
        varData  = data;
        vars[idx] = data;
        @(negedge clk_sys);
        varWrite = 1'b0;
    endtask

    task automatic run_cmd(input srg_pkg::srg_cmd_type c);
        logic [3:0][31:0] w;
        logic [31:0]      mx;
        logic [3:0]       mask;
        logic [31:0]      takeCyc;
        logic [31:0]      ovh;
        int               tmo;
        w = eff_widths(c, mx, mask);
        ovh = (c.mode == srg_pkg::MODE_SHAPED2) ? ticks(`SRG_OVH_TWO_NS) :
              (c.mode == srg_pkg::MODE_SHAPED3) ? ticks(`SRG_OVH_THREE_NS) : 0;
        @(negedge clk_sys);
        cmd      = c;
        cmdValid = 1'b1;
        tmo = 0;
        while (cmdReady !== 1'b1 && tmo < 2000)
        begin
            @(negedge clk_sys);
            tmo++;
        end
        @(negedge clk_sys);
        cmdValid = 1'b0;
        // cyc has already stepped past the taking edge
        takeCyc  = cyc - 32'h1;
        check(busy, 1, "busy after take");
        tmo = 0;
        while (busy !== 1'b0 && tmo < 5000)
        begin
            @(negedge clk_sys);
            tmo++;
        end
        check(busy, 0, "group end");
        repeat (2) @(negedge clk_sys);
        check(ampRiseCyc - takeCyc, 2 + ovh, "amp start delay");
        check(ampLen, c.lead + (mx == 0 ? 1 : mx) + c.lag, "amp window");
        check(loadCount, 1, "phase loads");
        check(loadAt, 0, "phase load moment");
        check(stray, 0, "gate outside amp or stray waveform");
        for (int i = 0; i < 4; i++)
        begin
            check(gateLen[i], w[i], "gate length");
            if (w[i] != 0)
                check(gateOn[i], c.lead + ((mx - w[i]) >> 1), "gate start");
            check(32'(rf.waveShape[i]), (c.mode[1] && w[i] != 0) ? 32'(c.shape[i]) : 0, "shape");
            if (mask[i])
                check(32'(rf.phase[i]), 32'(vars[c.phaseSel[i]]), "phase");
        end
    endtask

    task automatic send(input logic [1:0] m, input logic [31:0] w0, w1, w2, w3, lead, lag);
        srg_pkg::srg_cmd_type c;
        c.mode  = srg_pkg::srg_mode_type'(m);
        c.width = {w3[23:0], w2[23:0], w1[23:0], w0[23:0]};
        for (int i = 0; i < 4; i++)
        begin
            c.phaseSel[i] = 4'($urandom);
            c.shape[i]    = ($urandom_range(0, 3) == 0) ? 6'h00 : 6'($urandom);
        end
        c.lead = lead[23:0];
        c.lag  = lag[23:0];
        run_cmd(c);
    endtask

    function automatic logic [31:0] rand_width();
        return ($urandom_range(0, 3) == 0) ? 32'h0 : 32'($urandom_range(1, 300));
    endfunction

    initial
    begin
        rst      = 1'b1;
        cmdValid = 1'b0;
        cmd      = '0;
        varWrite = 1'b0;
        varIndex = '0;
        varData  = '0;
        num_errors  = 0;
        check_count = 0;
        void'($urandom(32'hd4c16e3e));
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check({busy, cmdReady, rf.ampGate, rf.gate}, 32'h20, "reset outputs");
        for (int i = 0; i < 16; i++)
            write_var(4'(i), 8'($urandom));
        send(2'b01, 10, 4, 0, 10, 2, 3);
        send(2'b00, 100, 95, 87, 50, 0, 0);
        send(2'b00, 100, 76, 70, 9, 1, 0);
        send(2'b01, 0, 0, 0, 0, 3, 4);
        send(2'b10, 40, 20, 30, 30, 2, 2);
        send(2'b11, 30, 0, 60, 5, 0, 1);
        send(2'b11, 12, 12, 0, 0, 5, 0);
        // random groups also change phase variables between pulses
        for (int n = 0; n < 40; n++)
        begin
            if ($urandom_range(0, 3) == 0)
                write_var(4'($urandom), 8'($urandom));
            send(2'($urandom), rand_width(), rand_width(), rand_width(), rand_width(),
                 $urandom_range(0, 20), $urandom_range(0, 20));
        end
        stop_test();
    end

    // generous bound: every group is well under a thousand cycles
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule
